// File: umlsf_regs.svh
// Behaviour
// - aux one driven low when bit set
// - interrupt output tri-stated unless enable bit set
// - loopback bit selects local diagnostic loopback
// - any received character but a pause character ends software pause
// - infrared routing; transmit rests low in infrared loopback
// - prescale by sixteen, optionally four more
// - data-ready flag while receive data waits
// - overrun when full; character not transferred
// - parity flag follows receive head character
// - framing flag follows receive head character
// - break flag; one break character per break
// - holding-empty set on empty, cleared on load
// - transmitter empty needs holding and shifter empty
// - summary error cleared on read unless remaining
// - change flags on toggles; cleared by read
// - ring change only on low-to-high input edge
// - auto clear-to-send high stops next character
// - upper modem status inverted inputs or loopback
// - scratch register stores eight bits
// - dual flow characters form two-character sequence
// - flow select codes for transmit and receive
// - upper modem control writable only when enhanced
`ifndef UMLSF_REGS_SVH
`define UMLSF_REGS_SVH
`define UMLSF_OFF_EFR 4'h2
`define UMLSF_OFF_MCR 4'h4
`define UMLSF_OFF_LSR 4'h5
`define UMLSF_OFF_MSR 4'h6
`define UMLSF_OFF_SCR 4'h7
`define UMLSF_OFF_RES1 4'h8
`define UMLSF_OFF_RES2 4'h9
`define UMLSF_OFF_PAU1 4'hA
`define UMLSF_OFF_PAU2 4'hB
`define UMLSF_MCR_DTR 0
`define UMLSF_MCR_RTS 1
`define UMLSF_MCR_AUX1 2
`define UMLSF_MCR_IRQEN 3
`define UMLSF_MCR_LOOP 4
`define UMLSF_MCR_ANY 5
`define UMLSF_MCR_IRDA 6
`define UMLSF_MCR_PRE 7
`define UMLSF_EFR_ENH 4
`define UMLSF_EFR_ACTS 7
`define UMLSF_REG_RST 8'h00
`define UMLSF_PRE_BASE 6'h10
`define UMLSF_PRE_EXTRA 6'h04
`endif

// File: umlsf_pkg.sv
package umlsf_pkg;
  // one finished character from the receiver
  typedef struct packed {
    logic done;
    logic perr;
    logic ferr;
    logic brk;
    logic [7:0] data;
  } umlsf_rx_evt_t;
  // error flags of the receive head entry
  typedef struct packed {
    logic perr;
    logic ferr;
    logic brk;
  } umlsf_head_t;
  // active-low modem lines
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } umlsf_modem_t;
  typedef enum logic [2:0] {
    FL_IDLE = 3'b001,
    FL_P1 = 3'b010,
    FL_R1 = 3'b100
  } umlsf_flow_t;
endpackage

// File: umlsf_sync.sv
module umlsf_sync (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [4:0] i_async,
  output logic [4:0] o_level
);
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] s3_q;
  genvar b;
  ////////////////////////////////////////////////////////////////
  // three stages; level moves only when stages two and three agree
  for (b = 0; b < 5; b++) begin : g_bit
    always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
        s1_q[b] <= 1'b1;
        s2_q[b] <= 1'b1;
        s3_q[b] <= 1'b1;
        o_level[b] <= 1'b1;
      end else begin
        s1_q[b] <= i_async[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        if (s2_q[b] == s3_q[b]) begin
          o_level[b] <= s3_q[b];
        end
      end
    end
  end
endmodule

// File: umlsf_prescale.sv
`include "umlsf_regs.svh"
module umlsf_prescale (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_div4,
  output logic o_tick
);
  logic [5:0] cnt_q;
  logic [5:0] limit;
  ////////////////////////////////////////////////////////////////
  // sixteen, or sixteen times four when the extra stage is on
  assign limit = i_div4 ? 6'(`UMLSF_PRE_BASE * `UMLSF_PRE_EXTRA - 1)
                        : 6'(`UMLSF_PRE_BASE - 1);
  // wrap also when limit shrinks mid count
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cnt_q <= 6'h00;
    end else if (cnt_q >= limit) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  assign o_tick = (cnt_q == limit);
endmodule

// File: umlsf_top.sv
`include "umlsf_regs.svh"
module umlsf_top (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire umlsf_pkg::umlsf_modem_t i_modem,
  input wire logic i_rx_pin,
  output logic o_rx_serial,
  input wire logic i_tx_serial,
  output logic o_tx_pin,
  output logic o_irda_sel,
  output logic o_aux_out_two_n,
  input wire umlsf_pkg::umlsf_rx_evt_t i_rx_evt,
  output logic o_rx_push,
  input wire logic i_rx_full,
  input wire logic i_rx_empty,
  input wire umlsf_pkg::umlsf_head_t i_rx_head,
  input wire logic i_rx_err_any,
  input wire logic i_tx_load,
  input wire logic i_tx_empty,
  input wire logic i_tx_shift_empty,
  input wire logic i_int_req,
  output logic o_int,
  output logic o_int_oe,
  output logic o_baud_tick,
  output logic o_tx_stop,
  output logic o_sw_paused,
  output logic [1:0] o_tx_sw_sel,
  output logic o_msr_event,
  output logic o_thr_empty
);
  logic [7:0] mcr_q;
  logic [2:0] mcr_hi_q;
  logic [7:0] mcr_eff;
  logic [7:0] efr_q;
  logic [7:0] scr_q;
  logic [7:0] res1_q;
  logic [7:0] res2_q;
  logic [7:0] pau1_q;
  logic [7:0] pau2_q;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [3:0] delta_q;
  logic [3:0] delta_set;
  logic ovr_q;
  logic err_sum_q;
  logic brk_q;
  logic thr_empty_q;
  logic loop;
  logic aux_one_n;
  logic aux_two_n;
  logic [4:0] pin_lvl;
  umlsf_pkg::umlsf_modem_t ext_m;
  umlsf_pkg::umlsf_modem_t eff_m;
  umlsf_pkg::umlsf_modem_t prev_q;
  umlsf_pkg::umlsf_flow_t fl_q;
  logic wr_efr;
  logic wr_mcr;
  logic rd_lsr;
  logic rd_msr;
  logic rx_ok;
  logic pause_det;
  logic resume_det;
  logic any_resume;
  logic paused_q;
  logic [7:0] ch;

  ////////////////////////////////////////////////////////////////
  // register strobes
  assign wr_efr = i_wr && (i_addr == `UMLSF_OFF_EFR);
  assign wr_mcr = i_wr && (i_addr == `UMLSF_OFF_MCR);
  assign rd_lsr = i_rd && (i_addr == `UMLSF_OFF_LSR);
  assign rd_msr = i_rd && (i_addr == `UMLSF_OFF_MSR);

  // plain control bytes; writes anywhere else are dropped
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      efr_q <= `UMLSF_REG_RST;
      scr_q <= `UMLSF_REG_RST;
      res1_q <= `UMLSF_REG_RST;
      res2_q <= `UMLSF_REG_RST;
      pau1_q <= `UMLSF_REG_RST;
      pau2_q <= `UMLSF_REG_RST;
    end else if (i_wr) begin
      unique case (i_addr)
        `UMLSF_OFF_EFR: efr_q <= i_wdata;
        `UMLSF_OFF_SCR: scr_q <= i_wdata;
        `UMLSF_OFF_RES1: res1_q <= i_wdata;
        `UMLSF_OFF_RES2: res2_q <= i_wdata;
        `UMLSF_OFF_PAU1: pau1_q <= i_wdata;
        `UMLSF_OFF_PAU2: pau2_q <= i_wdata;
        default: ;
      endcase
    end
  end

  // upper modem bits kept aside, written only when unlocked
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      mcr_q <= `UMLSF_REG_RST;
      mcr_hi_q <= 3'h0;
    end else if (wr_mcr) begin
      mcr_q <= i_wdata;
      if (efr_q[`UMLSF_EFR_ENH]) begin
        mcr_hi_q <= i_wdata[7:5];
      end
    end
  end

  // locked bits show defaults but the saved copy survives
  assign mcr_eff = {efr_q[`UMLSF_EFR_ENH] ? mcr_hi_q : 3'h0,
                    mcr_q[4:0]};

  ////////////////////////////////////////////////////////////////
  // modem side
  assign loop = mcr_eff[`UMLSF_MCR_LOOP];
  assign aux_one_n = ~mcr_eff[`UMLSF_MCR_AUX1];
  assign aux_two_n = ~mcr_eff[`UMLSF_MCR_IRQEN];

  umlsf_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_async({i_rx_pin, i_modem}),
    .o_level(pin_lvl)
  );
  assign ext_m = pin_lvl[3:0];

  // loopback cuts the pins off and feeds back our own controls
  always_comb begin
    if (loop) begin
      eff_m.cts_n = ~mcr_eff[`UMLSF_MCR_RTS];
      eff_m.dsr_n = ~mcr_eff[`UMLSF_MCR_DTR];
      eff_m.ri_n = aux_one_n;
      eff_m.cd_n = aux_two_n;
    end else begin
      eff_m = ext_m;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      prev_q <= 4'hF;
    end else begin
      prev_q <= eff_m;
    end
  end

  // ring counts only its trailing edge, low to high
  assign delta_set = {eff_m.cd_n ^ prev_q.cd_n,
                      eff_m.ri_n & ~prev_q.ri_n,
                      eff_m.dsr_n ^ prev_q.dsr_n,
                      eff_m.cts_n ^ prev_q.cts_n};

  // a change in the read cycle survives the clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      delta_q <= 4'h0;
    end else begin
      delta_q <= delta_set | (delta_q & {4{~rd_msr}});
    end
  end

  assign modem_status = {~eff_m, delta_q};
  assign o_msr_event = |delta_q;

  ////////////////////////////////////////////////////////////////
  // serial routing
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_tx_pin <= 1'b1;
      o_rx_serial <= 1'b1;
    end else begin
      // idle level depends on the line coding in use
      o_tx_pin <= loop ? ~mcr_eff[`UMLSF_MCR_IRDA]
                       : i_tx_serial;
      o_rx_serial <= loop ? i_tx_serial : pin_lvl[4];
    end
  end

  assign o_irda_sel = mcr_eff[`UMLSF_MCR_IRDA];
  assign o_aux_out_two_n = loop ? 1'b1 : aux_two_n;
  assign o_int_oe = mcr_eff[`UMLSF_MCR_IRQEN];
  assign o_int = o_int_oe & i_int_req;
  assign o_tx_stop = efr_q[`UMLSF_EFR_ACTS] & eff_m.cts_n;
  assign o_tx_sw_sel = efr_q[3:2];

  umlsf_prescale u_pre (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_div4(mcr_eff[`UMLSF_MCR_PRE]),
    .o_tick(o_baud_tick)
  );

  ////////////////////////////////////////////////////////////////
  // receive transfer: a full store keeps its contents
  assign rx_ok = i_rx_evt.done && !(i_rx_evt.brk && brk_q);
  assign o_rx_push = rx_ok && !i_rx_full;

  // one break entry per break, rearmed by a normal character
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      brk_q <= 1'b0;
    end else if (i_rx_evt.done) begin
      brk_q <= i_rx_evt.brk;
    end
  end

  // overrun sticks until status is read; a new one wins
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ovr_q <= 1'b0;
    end else if (i_rx_evt.done && i_rx_full) begin
      ovr_q <= 1'b1;
    end else if (rd_lsr) begin
      ovr_q <= 1'b0;
    end
  end

  // summary stays while errors still sit in the store
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      err_sum_q <= 1'b0;
    end else begin
      err_sum_q <= i_rx_err_any | (err_sum_q & ~rd_lsr);
    end
  end

  // load clears, an empty holding stage sets
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      thr_empty_q <= 1'b1;
    end else if (i_tx_load) begin
      thr_empty_q <= 1'b0;
    end else if (i_tx_empty) begin
      thr_empty_q <= 1'b1;
    end
  end
  assign o_thr_empty = thr_empty_q;

  // head flags are meaningless with nothing stored
  assign line_status = {err_sum_q,
                thr_empty_q & i_tx_shift_empty,
                thr_empty_q,
                i_rx_head.brk & ~i_rx_empty,
                i_rx_head.ferr & ~i_rx_empty,
                i_rx_head.perr & ~i_rx_empty,
                ovr_q,
                ~i_rx_empty};

  ////////////////////////////////////////////////////////////////
  // software flow character matching
  assign ch = i_rx_evt.data;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      fl_q <= umlsf_pkg::FL_IDLE;
    end else if (i_rx_evt.done && efr_q[1:0] == 2'h3) begin
      unique case (fl_q)
        umlsf_pkg::FL_IDLE:
          if (ch == pau1_q) begin
            fl_q <= umlsf_pkg::FL_P1;
          end else if (ch == res1_q) begin
            fl_q <= umlsf_pkg::FL_R1;
          end
        umlsf_pkg::FL_P1: fl_q <= umlsf_pkg::FL_IDLE;
        umlsf_pkg::FL_R1: fl_q <= umlsf_pkg::FL_IDLE;
      endcase
    end else if (efr_q[1:0] != 2'h3) begin
      fl_q <= umlsf_pkg::FL_IDLE;
    end
  end

  // pair must arrive back to back; any other character resets
  always_comb begin
    pause_det = 1'b0;
    resume_det = 1'b0;
    if (i_rx_evt.done) begin
      unique case (efr_q[1:0])
        2'h2: begin
          pause_det = (ch == pau1_q);
          resume_det = (ch == res1_q);
        end
        2'h1: begin
          pause_det = (ch == pau2_q);
          resume_det = (ch == res2_q);
        end
        2'h3: begin
          pause_det = (fl_q == umlsf_pkg::FL_P1) && (ch == pau2_q);
          resume_det = (fl_q == umlsf_pkg::FL_R1) && (ch == res2_q);
        end
        2'h0: ;
      endcase
    end
  end

  assign any_resume = i_rx_evt.done && mcr_eff[`UMLSF_MCR_ANY];

  // a pause character beats the any-character resume
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      paused_q <= 1'b0;
    end else if (pause_det) begin
      paused_q <= 1'b1;
    end else if (resume_det || any_resume) begin
      paused_q <= 1'b0;
    end
  end
  assign o_sw_paused = paused_q;

  ////////////////////////////////////////////////////////////////
  // read port: data stands one cycle, zero otherwise
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || !i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_addr)
        `UMLSF_OFF_EFR: o_rdata <= efr_q;
        `UMLSF_OFF_MCR: o_rdata <= mcr_eff;
        `UMLSF_OFF_LSR: o_rdata <= line_status;
        `UMLSF_OFF_MSR: o_rdata <= modem_status;
        `UMLSF_OFF_SCR: o_rdata <= scr_q;
        `UMLSF_OFF_RES1: o_rdata <= res1_q;
        `UMLSF_OFF_RES2: o_rdata <= res2_q;
        `UMLSF_OFF_PAU1: o_rdata <= pau1_q;
        `UMLSF_OFF_PAU2: o_rdata <= pau2_q;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  sequence scr_wr_s;
    i_wr && i_addr == `UMLSF_OFF_SCR;
  endsequence
  sequence scr_rd_s;
    i_rd && i_addr == `UMLSF_OFF_SCR && !i_wr;
  endsequence

  scratch_hold_a: assert property (
    scr_wr_s ##1 !i_wr ##1 scr_rd_s |=> o_rdata == $past(i_wdata, 3))
    else $error("scratch lost its value");

  rx_full_drop_a: assert property (
    i_rx_evt.done && i_rx_full |-> !o_rx_push ##1 ovr_q)
    else $error("character pushed into full store");

  ring_edge_a: assert property (
    $fell(eff_m.ri_n) && !delta_q[2] |=> !delta_q[2])
    else $error("ring flag set on falling edge");

  cts_delta_a: assert property (
    $changed(eff_m.cts_n) |=> delta_q[0])
    else $error("clear-to-send change missed");

  msr_clear_a: assert property (
    rd_msr && delta_set == 4'h0 |=> delta_q == 4'h0)
    else $error("change flags survived read");

  int_drive_a: assert property (
    !mcr_eff[`UMLSF_MCR_IRQEN] |-> !o_int_oe && !o_int)
    else $error("interrupt driven while disabled");

  loop_idle_a: assert property (
    loop && !mcr_eff[`UMLSF_MCR_IRDA] |=> o_tx_pin)
    else $error("transmit pin not idle in loopback");

  mcr_lock_a: assert property (
    wr_mcr && !efr_q[`UMLSF_EFR_ENH] |=> $stable(mcr_hi_q))
    else $error("locked modem bits changed");

  tick_gap_a: assert property (
    o_baud_tick |=> !o_baud_tick [*8])
    else $error("prescale ticks too close");

  auto_cts_a: assert property (
    efr_q[`UMLSF_EFR_ACTS] && eff_m.cts_n |-> o_tx_stop)
    else $error("transmit not stopped by clear-to-send");

  data_ready_a: assert property (
    rd_lsr |=> o_rdata[0] == !$past(i_rx_empty))
    else $error("data-ready flag wrong");
endmodule

// File: umlsf_peer.sv
module umlsf_peer (
  input wire logic i_clk_sys,
  input wire logic [3:0] i_want,
  input wire logic i_slow,
  input wire logic i_rx_level,
  output umlsf_pkg::umlsf_modem_t o_modem,
  output logic o_rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lag_q;
  // all lines start inactive; the receive line rests at mark, as pulled up
  initial begin
    o_modem = 4'hF;
    o_rx_pin = 1'b1;
    lag_q = 4'h0;
  end
  // lines follow the request at once or five clocks late, so the
  // synchroniser sees both tidy and late edges
  // ring is active low, released high
  // cts_n high asks the channel to pause after the character
  always @(posedge i_clk_sys) begin
    o_rx_pin <= i_rx_level;
    if (o_modem !== i_want && lag_q < (i_slow ? 4'h5 : 4'h0)) begin
      lag_q <= lag_q + 4'h1;
    end else begin
      lag_q <= 4'h0;
      o_modem <= i_want;
    end
  end
endmodule

// File: uart_modem_line_status_flow_test.sv
module uart_modem_line_status_flow_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic [3:0] addr = 4'h0, want = 4'hF;
  logic [7:0] wdata = 8'h00, rdata, d, g;
  umlsf_pkg::umlsf_modem_t modem;
  umlsf_pkg::umlsf_rx_evt_t evt = 12'h000;
  umlsf_pkg::umlsf_head_t head = 3'h0;
  logic rx_pin, rx_ser, tx_ser = 1'b1, tx_pin, irda, aux2n, push, rxl = 1'b1;
  logic full = 1'b0, empty = 1'b1, errany = 1'b0, txload = 1'b0;
  logic txempty = 1'b1, shempty = 1'b1, intreq = 1'b0, int_o, int_oe;
  logic tick, txstop, paused, msrev, thre;
  logic [1:0] swsel;
  int err_count = 0, total_checks = 0, n;

  always #10 clk = ~clk;

  umlsf_peer umlsf_peer_inst (.i_clk_sys(clk), .i_want(want),
    .i_slow(slow), .i_rx_level(rxl), .o_modem(modem), .o_rx_pin(rx_pin));
  umlsf_top umlsf_top_inst (.i_clk_sys(clk), .i_reset_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_modem(modem), .i_rx_pin(rx_pin), .o_rx_serial(rx_ser),
    .i_tx_serial(tx_ser), .o_tx_pin(tx_pin), .o_irda_sel(irda),
    .o_aux_out_two_n(aux2n), .i_rx_evt(evt), .o_rx_push(push),
    .i_rx_full(full), .i_rx_empty(empty), .i_rx_head(head),
    .i_rx_err_any(errany), .i_tx_load(txload), .i_tx_empty(txempty),
    .i_tx_shift_empty(shempty), .i_int_req(intreq), .o_int(int_o),
    .o_int_oe(int_oe), .o_baud_tick(tick), .o_tx_stop(txstop),
    .o_sw_paused(paused), .o_tx_sw_sel(swsel), .o_msr_event(msrev),
    .o_thr_empty(thre));

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  // one-cycle strobes launched just after an edge
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("register", rdata & m, e);
  endtask

  // receive event set at an edge and held until the next call; push is combinational
  task automatic rxev(input logic [11:0] e);
    @(posedge clk);
    evt <= e;
    @(negedge clk);
  endtask

  task automatic settle;
    repeat (3) @(negedge clk);
  endtask

  task automatic gap;
    n = 0;
    while (tick !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    g = 8'h01;
    @(negedge clk);
    while (tick !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
      g++;
    end
  endtask

  // move the lines, wait for the change flag, read twice
  task automatic mtog(input logic [3:0] w, input logic fl,
                      input logic [7:0] e);
    want <= w;
    for (n = 0; n < 40 && (msrev !== 1'b1 || !fl); n++) @(negedge clk);
    chk("change", {7'h00, msrev}, {7'h00, fl});
    rchk(4'h6, 8'hFF, e);
    rchk(4'h6, 8'h0F, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs well under a thousand clocks
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rchk(4'h5, 8'hFF, 8'h60);
    rchk(4'h6, 8'hFF, 8'h00);
    rchk(4'h4, 8'hFF, 8'h00);
    chk("tx pin", {7'h00, tx_pin}, 8'h01);
    chk("int oe", {7'h00, int_oe}, 8'h00);
    // scratch patterns, then an unmapped place that must stay empty
    for (int i = 0; i < 8; i++) begin
      wreg(4'h7, 8'h01 << i);
      rchk(4'h7, 8'hFF, 8'h01 << i);
    end
    wreg(4'h7, 8'h5A);
    rchk(4'h7, 8'hFF, 8'h5A);
    wreg(4'hF, 8'h55);
    rchk(4'hF, 8'hFF, 8'h00);
    // upper control bits locked until enhanced mode
    wreg(4'h4, 8'hE0);
    rchk(4'h4, 8'hFF, 8'h00);
    wreg(4'h2, 8'h10);
    wreg(4'h4, 8'hE0);
    rchk(4'h4, 8'hFF, 8'hE0);
    wreg(4'h2, 8'h00);
    rchk(4'h4, 8'hFF, 8'h00);
    wreg(4'h2, 8'h10);
    rchk(4'h4, 8'hFF, 8'hE0);
    wreg(4'h4, 8'h08);
    intreq <= 1'b1;
    settle();
    chk("int", {6'h00, int_oe, int_o}, 8'h03);
    chk("aux two", {7'h00, aux2n}, 8'h00);
    wreg(4'h4, 8'h00);
    settle();
    chk("int", {6'h00, int_oe, int_o}, 8'h00);
    // receive pin reaches the receiver through the synchroniser
    rxl <= 1'b0;
    repeat (8) @(negedge clk);
    chk("rx serial", {7'h00, rx_ser}, 8'h00);
    rxl <= 1'b1;
    // loopback: status mirrors control bits, external lines ignored
    want <= 4'h0;
    wreg(4'h4, 8'h1A);
    rchk(4'h6, 8'hF0, 8'h90);
    wreg(4'h4, 8'h15);
    rchk(4'h6, 8'hF0, 8'h60);
    chk("loop pins", {6'h00, tx_pin, aux2n}, 8'h03);
    tx_ser <= 1'b0;
    settle();
    chk("rx serial", {7'h00, rx_ser}, 8'h00);
    tx_ser <= 1'b1;
    wreg(4'h4, 8'h50);
    settle();
    chk("ir loop", {6'h00, tx_pin, irda}, 8'h01);
    wreg(4'h4, 8'h00);
    want <= 4'hF;
    repeat (30) @(negedge clk);
    rchk(4'h6, 8'hF0, 8'h00);
    // prescaler spacing
    gap();
    chk("tick gap", g, 8'h10);
    wreg(4'h4, 8'h80);
    gap();
    gap();
    chk("tick gap", g, 8'h40);
    wreg(4'h4, 8'h00);
    // modem change flags, ring only on its rising edge
    mtog(4'hE, 1'b1, 8'h11);
    mtog(4'hA, 1'b0, 8'h50);
    mtog(4'hE, 1'b1, 8'h14);
    slow <= 1'b1;
    mtog(4'hC, 1'b1, 8'h32);
    mtog(4'h4, 1'b1, 8'hB8);
    mtog(4'hF, 1'b1, 8'h0B);
    // automatic clear-to-send pause
    wreg(4'h2, 8'h90);
    settle();
    chk("tx stop", {7'h00, txstop}, 8'h01);
    mtog(4'hE, 1'b1, 8'h11);
    chk("tx stop", {7'h00, txstop}, 8'h00);
    mtog(4'hF, 1'b1, 8'h01);
    wreg(4'h2, 8'h10);
    settle();
    chk("tx stop", {7'h00, txstop}, 8'h00);
    // line status flags
    empty <= 1'b0;
    rchk(4'h5, 8'h01, 8'h01);
    head <= 3'b100;
    rchk(4'h5, 8'h1C, 8'h04);
    head <= 3'b010;
    rchk(4'h5, 8'h1C, 8'h08);
    head <= 3'b001;
    rchk(4'h5, 8'h1C, 8'h10);
    head <= 3'b000;
    errany <= 1'b1;
    rchk(4'h5, 8'h80, 8'h80);
    rchk(4'h5, 8'h80, 8'h80);
    errany <= 1'b0;
    rchk(4'h5, 8'h80, 8'h80);
    rchk(4'h5, 8'h80, 8'h00);
    full <= 1'b1;
    rxev(12'h841);
    chk("push", {7'h00, push}, 8'h00);
    rxev(12'h000);
    rchk(4'h5, 8'h02, 8'h02);
    rchk(4'h5, 8'h02, 8'h00);
    full <= 1'b0;
    rxev(12'h900);
    chk("push", {7'h00, push}, 8'h01);
    rxev(12'h900);
    chk("push", {7'h00, push}, 8'h00);
    rxev(12'h841);
    chk("push", {7'h00, push}, 8'h01);
    rxev(12'h000);
    txempty <= 1'b0;
    txload <= 1'b1;
    @(negedge clk);
    txload <= 1'b0;
    chk("thr empty", {7'h00, thre}, 8'h00);
    rchk(4'h5, 8'h60, 8'h00);
    txempty <= 1'b1;
    shempty <= 1'b0;
    rchk(4'h5, 8'h60, 8'h20);
    shempty <= 1'b1;
    rchk(4'h5, 8'h60, 8'h60);
    // software flow: pause, resume, any-character, dual
    wreg(4'h2, 8'h12);
    wreg(4'hA, 8'h13);
    wreg(4'h8, 8'h11);
    wreg(4'hB, 8'h14);
    rxev(12'h813);
    rxev(12'h841);
    rxev(12'h000);
    chk("paused", {7'h00, paused}, 8'h01);
    rxev(12'h811);
    rxev(12'h000);
    chk("paused", {7'h00, paused}, 8'h00);
    wreg(4'h4, 8'h20);
    rxev(12'h813);
    rxev(12'h000);
    chk("paused", {7'h00, paused}, 8'h01);
    rxev(12'h841);
    rxev(12'h000);
    chk("paused", {7'h00, paused}, 8'h00);
    wreg(4'h2, 8'h13);
    rxev(12'h813);
    rxev(12'h814);
    rxev(12'h000);
    chk("paused", {7'h00, paused}, 8'h01);
    // second character set alone, any-character resume off
    wreg(4'h4, 8'h00);
    wreg(4'h2, 8'h11);
    wreg(4'h9, 8'h16);
    rxev(12'h816);
    rxev(12'h000);
    chk("paused", {7'h00, paused}, 8'h00);
    rxev(12'h814);
    rxev(12'h000);
    chk("paused", {7'h00, paused}, 8'h01);
    for (int v = 0; v < 4; v++) begin
      wreg(4'h2, 8'h10 | (v[7:0] << 2));
      @(negedge clk);
      chk("tx select", {6'h00, swsel}, v[7:0]);
    end
    report_and_stop();
  end
endmodule
